// [hw/hcr_pkg.sv]
package hcr_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0]  HCR_OFFSET       = 8'h52;
    localparam int          HCR_LED_HI       = 7;
    localparam int          HCR_LED_LO       = 6;
    localparam int          HCR_DRV_BIT      = 5;
    localparam int          HCR_POL_BIT      = 4;
    localparam int          HCR_MEM_BIT      = 3;
    localparam int          HCR_IO_BIT       = 2;
    localparam int          HCR_PM_BIT       = 0;
    localparam logic [7:0]  HCR_RDATA_IDLE   = 8'h00;
    // ==========================================================
    // Eeprom mode codes
    localparam logic [1:0]  HCR_EEM_AUTOLOAD = 2'h1;
    localparam logic [1:0]  HCR_EEM_CFG_WR   = 2'h3;
    // ==========================================================
    // Power management capability
    localparam logic [7:0]  HCR_CAP_PTR      = 8'h50;
    localparam logic [7:0]  HCR_CAP_ID       = 8'h01;
    localparam logic [7:0]  HCR_CAP_NONE     = 8'h00;
    localparam logic [7:0]  HCR_PM_FIRST     = 8'h52;
    localparam logic [7:0]  HCR_PM_LAST      = 8'h57;
    // ==========================================================
    // Timing
    localparam int          HCR_CLK_HZ       = 40000000;
    localparam int          HCR_WAKE_PULSE_MS = 150;
    localparam int          HCR_AUTOLOAD_MS  = 2;
    localparam int          HCR_WAKE_CYCLES  = HCR_WAKE_PULSE_MS * (HCR_CLK_HZ / 1000);
    localparam int          HCR_LOAD_CYCLES  = HCR_AUTOLOAD_MS * (HCR_CLK_HZ / 1000);
    localparam int          HCR_CNT_W        = 24;
    localparam logic [23:0] HCR_CNT_ZERO     = 24'h000000;
    localparam logic [23:0] HCR_CNT_ONE      = 24'h000001;
    // ==========================================================
    // Reload sequencer
    typedef enum logic [2:0] {
        HCR_ST_IDLE    = 3'b001,
        HCR_ST_RELOAD  = 3'b010,
        HCR_ST_RESTORE = 3'b100
    } hcr_state_e;
endpackage

// [hw/hcr_wake_shaper.sv]
`timescale 1ns/1ps
module hcr_wake_shaper
    import hcr_pkg::*;
#(
    parameter int PULSE_CYCLES = HCR_WAKE_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst_n,
    input  wire logic wake_event,
    input  wire logic wake_pin_polarity,
    input  wire logic wake_pin_pulse_select,
    output logic      wake_output_pin
);
    logic                 evt_d_r;
    logic                 evt_d_nxt;
    logic [HCR_CNT_W-1:0] cnt_r;
    logic [HCR_CNT_W-1:0] cnt_nxt;
    logic                 pin_nxt;
    logic                 active;

    // ==========================================================
    // Output style
    always_comb begin
        evt_d_nxt = wake_event;
        if (wake_event && !evt_d_r && wake_pin_pulse_select) begin
            cnt_nxt = PULSE_CYCLES[HCR_CNT_W-1:0];
        end else if (cnt_r != HCR_CNT_ZERO) begin
            cnt_nxt = cnt_r - HCR_CNT_ONE;
        end else begin
            cnt_nxt = HCR_CNT_ZERO;
        end
        active  = wake_pin_pulse_select ? (cnt_nxt != HCR_CNT_ZERO) : wake_event;
        pin_nxt = active ^ wake_pin_polarity;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_d_r         <= 1'b0;
            cnt_r           <= HCR_CNT_ZERO;
            wake_output_pin <= 1'b0;
        end else begin
            evt_d_r         <= evt_d_nxt;
            cnt_r           <= cnt_nxt;
            wake_output_pin <= pin_nxt;
        end
    end

    a_level_style: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !wake_pin_pulse_select |=> wake_output_pin == ($past(wake_event) ^ $past(wake_pin_polarity)))
        else $error("wake level style wrong");
    a_pulse_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (wake_pin_pulse_select && wake_event && !evt_d_r && PULSE_CYCLES > 1)
        |=> (wake_output_pin != $past(wake_pin_polarity)))
        else $error("wake pulse did not start");
endmodule // hcr_wake_shaper

// [hw/hcr_top.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - LED mode loaded from eeprom, not constant
// - Driver flag reads back what software wrote
// - PCI command enable write clears driver flag
// - Polarity and pulse select choose wake style
// - Bit 3 read-only memory mapping indicator
// - Bit 2 read-only io mapping; bit 1 reserved
// - PM registers span config offsets 52h-57h
// - Auto-load reloads defaults in 2 ms, returns
module hcr_top
    import hcr_pkg::*;
#(
    parameter int LOAD_CYCLES = HCR_LOAD_CYCLES,
    parameter int WAKE_CYCLES = HCR_WAKE_CYCLES
) (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [1:0] eeprom_mode_select,
    input  wire logic [1:0] eeprom_led_default,
    input  wire logic       pci_cmd_enable_write,
    input  wire logic       wake_pin_pulse_select,
    input  wire logic       memory_space_mapped,
    input  wire logic       io_space_mapped,
    input  wire logic       wake_event,
    input  wire logic [7:0] pm_cfg_addr,
    output logic            pm_cfg_hit,
    output logic      [1:0] led_mode_select,
    output logic            power_mgmt_enable,
    output logic            cap_list_status,
    output logic      [7:0] cap_pointer,
    output logic      [7:0] cap_id,
    output logic            cap_word_valid,
    output logic      [7:0] cap_next_ptr,
    output logic            autoload_done,
    output logic            wake_output_pin
);
    hcr_state_e           state_r;
    hcr_state_e           state_nxt;
    logic [HCR_CNT_W-1:0] cnt_r;
    logic [HCR_CNT_W-1:0] cnt_nxt;
    logic [1:0]           led_nxt;
    logic                 drv_r;
    logic                 drv_nxt;
    logic                 pol_r;
    logic                 pol_nxt;
    logic                 pm_nxt;
    logic [7:0]           rdata_nxt;
    logic                 done_nxt;
    logic                 hit_nxt;
    logic                 cfg_wr;

    // ==========================================================
    // Reload sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        done_nxt  = 1'b0;
        case (state_r)
            HCR_ST_IDLE: begin
                if (eeprom_mode_select == HCR_EEM_AUTOLOAD) begin
                    state_nxt = HCR_ST_RELOAD;
                    cnt_nxt   = LOAD_CYCLES[HCR_CNT_W-1:0];
                end
            end
            HCR_ST_RELOAD: begin
                if (cnt_r <= HCR_CNT_ONE) begin
                    state_nxt = HCR_ST_RESTORE;
                    cnt_nxt   = HCR_CNT_ZERO;
                end else begin
                    cnt_nxt = cnt_r - HCR_CNT_ONE;
                end
            end
            HCR_ST_RESTORE: begin
                state_nxt = HCR_ST_IDLE;
                done_nxt  = 1'b1;
            end
            default: begin
                state_nxt = HCR_ST_IDLE;
                cnt_nxt   = HCR_CNT_ZERO;
            end
        endcase
    end

    // ==========================================================
    // Register fields
    assign cfg_wr = reg_wr && (reg_addr == HCR_OFFSET)
                    && (eeprom_mode_select == HCR_EEM_CFG_WR);

    always_comb begin
        led_nxt = led_mode_select;
        drv_nxt = drv_r;
        pol_nxt = pol_r;
        pm_nxt  = power_mgmt_enable;
        if (state_r == HCR_ST_RESTORE) begin
            led_nxt = eeprom_led_default;
            drv_nxt = 1'b0;
            pol_nxt = 1'b0;
            pm_nxt  = 1'b0;
        end else if (cfg_wr) begin
            led_nxt = reg_wdata[HCR_LED_HI:HCR_LED_LO];
            drv_nxt = reg_wdata[HCR_DRV_BIT];
            pol_nxt = reg_wdata[HCR_POL_BIT];
            pm_nxt  = reg_wdata[HCR_PM_BIT];
        end
        if (pci_cmd_enable_write) begin
            drv_nxt = 1'b0;
        end
        rdata_nxt = HCR_RDATA_IDLE;
        if (reg_rd && reg_addr == HCR_OFFSET) begin
            rdata_nxt[HCR_LED_HI:HCR_LED_LO] = led_mode_select;
            rdata_nxt[HCR_DRV_BIT]           = drv_r;
            rdata_nxt[HCR_POL_BIT]           = pol_r;
            rdata_nxt[HCR_MEM_BIT]           = memory_space_mapped;
            rdata_nxt[HCR_IO_BIT]            = io_space_mapped;
            rdata_nxt[HCR_PM_BIT]            = power_mgmt_enable;
        end
        hit_nxt = pm_nxt && pm_cfg_addr >= HCR_PM_FIRST && pm_cfg_addr <= HCR_PM_LAST;
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r           <= HCR_ST_RESTORE;
            cnt_r             <= HCR_CNT_ZERO;
            led_mode_select   <= 2'h0;
            drv_r             <= 1'b0;
            pol_r             <= 1'b0;
            power_mgmt_enable <= 1'b0;
            reg_rdata         <= HCR_RDATA_IDLE;
            autoload_done     <= 1'b0;
            pm_cfg_hit        <= 1'b0;
            cap_list_status   <= 1'b0;
            cap_pointer       <= HCR_CAP_NONE;
            cap_id            <= HCR_CAP_NONE;
            cap_word_valid    <= 1'b0;
            cap_next_ptr      <= HCR_CAP_NONE;
        end else begin
            state_r           <= state_nxt;
            cnt_r             <= cnt_nxt;
            led_mode_select   <= led_nxt;
            drv_r             <= drv_nxt;
            pol_r             <= pol_nxt;
            power_mgmt_enable <= pm_nxt;
            reg_rdata         <= rdata_nxt;
            autoload_done     <= done_nxt;
            pm_cfg_hit        <= hit_nxt;
            cap_list_status   <= pm_nxt;
            cap_pointer       <= pm_nxt ? HCR_CAP_PTR : HCR_CAP_NONE;
            cap_id            <= pm_nxt ? HCR_CAP_ID : HCR_CAP_NONE;
            cap_word_valid    <= pm_nxt;
            cap_next_ptr      <= HCR_CAP_NONE;
        end
    end

    // ==========================================================
    // Wake pin
    hcr_wake_shaper #(
        .PULSE_CYCLES          (WAKE_CYCLES)
    ) u_wake (
        .sys_clk               (sys_clk),
        .rst_n                 (rst_n),
        .wake_event            (wake_event),
        .wake_pin_polarity     (pol_r),
        .wake_pin_pulse_select (wake_pin_pulse_select),
        .wake_output_pin       (wake_output_pin)
    );

    // ==========================================================
    // Checks
    a_led_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == HCR_ST_RESTORE |=> led_mode_select == $past(eeprom_led_default))
        else $error("led mode not loaded");
    a_drv_store: assert property (@(posedge sys_clk) disable iff (!rst_n)
        cfg_wr && !pci_cmd_enable_write && state_r == HCR_ST_IDLE
        |=> drv_r == $past(reg_wdata[HCR_DRV_BIT]))
        else $error("driver flag not stored");
    a_drv_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pci_cmd_enable_write |=> !drv_r)
        else $error("driver flag not cleared");
    a_map_bits: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_rd && reg_addr == HCR_OFFSET |=> reg_rdata[HCR_MEM_BIT] ==
        $past(memory_space_mapped) && reg_rdata[HCR_IO_BIT] == $past(io_space_mapped)
        && !reg_rdata[1])
        else $error("mapping bits wrong");
    a_cap_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
        power_mgmt_enable |-> cap_list_status && cap_pointer == HCR_CAP_PTR
        && cap_id == HCR_CAP_ID && cap_word_valid && cap_next_ptr == HCR_CAP_NONE)
        else $error("capability not exposed");
    a_cap_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        !power_mgmt_enable |-> !cap_list_status && cap_id == HCR_CAP_NONE
        && !cap_word_valid && cap_next_ptr == HCR_CAP_NONE)
        else $error("capability not hidden");
    a_pm_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
        pm_cfg_hit |-> power_mgmt_enable && $past(pm_cfg_addr) >= HCR_PM_FIRST
        && $past(pm_cfg_addr) <= HCR_PM_LAST)
        else $error("pm window wrong");
    a_wr_guard: assert property (@(posedge sys_clk) disable iff (!rst_n)
        reg_wr && eeprom_mode_select != HCR_EEM_CFG_WR && state_r == HCR_ST_IDLE
        |=> $stable(pol_r) && $stable(power_mgmt_enable) && $stable(led_mode_select))
        else $error("write outside enable mode");
    a_reload_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == HCR_ST_RESTORE |=> autoload_done && !drv_r && !power_mgmt_enable)
        else $error("reload did not finish");
endmodule // hcr_top

// [testbench/hcr_cmd_model.sv]
`timescale 1ns/1ps
// ==========================================================
// Eeprom command register as kept by host software
module hcr_cmd_model (
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       mode_wr,
    input  wire logic [1:0] mode_wdata,
    input  wire logic       autoload_done,
    output logic      [1:0] eeprom_mode_select
);
    logic [1:0] mode_r;
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            mode_r <= 2'h0;
        else if (autoload_done)
            mode_r <= 2'h0;
        else if (mode_wr)
            mode_r <= mode_wdata;
    end
    assign eeprom_mode_select = autoload_done ? 2'h0 : mode_r;
endmodule // hcr_cmd_model

// [testbench/test_host_config_register_one.sv]
`timescale 1ns/1ps
module test_host_config_register_one;
    import hcr_pkg::*;
    localparam int LC = 20;
    localparam int WC = 10;
    logic       sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, mode_wr = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pm_cfg_addr = 8'h00, wv, sh;
    logic [7:0] reg_rdata, cap_pointer, cap_id, cap_next_ptr;
    logic [1:0] eeprom_led_default = 2'h0, mode_wdata = 2'h0;
    logic [1:0] eeprom_mode_select, led_mode_select;
    logic       pci_cmd_enable_write = 1'b0, wake_pin_pulse_select = 1'b0, wake_event = 1'b0;
    logic       memory_space_mapped = 1'b0, io_space_mapped = 1'b0;
    logic       pm_cfg_hit, power_mgmt_enable, cap_list_status, cap_word_valid;
    logic       autoload_done, wake_output_pin;
    int         error_cnt = 0, tests_run = 0, seed = 32'h517f3dce, n, k;

    hcr_top #(.LOAD_CYCLES(LC), .WAKE_CYCLES(WC)) u_dut (.sys_clk, .rst_n, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .eeprom_mode_select, .eeprom_led_default,
        .pci_cmd_enable_write, .wake_pin_pulse_select, .memory_space_mapped,
        .io_space_mapped, .wake_event, .pm_cfg_addr, .pm_cfg_hit, .led_mode_select,
        .power_mgmt_enable, .cap_list_status, .cap_pointer, .cap_id, .cap_word_valid,
        .cap_next_ptr, .autoload_done, .wake_output_pin);
    hcr_cmd_model u_cmd (.sys_clk, .rst_n, .mode_wr, .mode_wdata, .autoload_done,
        .eeprom_mode_select);

    always #12.5 sys_clk = ~sys_clk;

    // ==========================================================
    // Expectation and bus tasks
    function automatic logic [7:0] exp_rd();
        return {sh[7:4], memory_space_mapped, io_space_mapped, 1'b0, sh[0]};
    endfunction
    task automatic tick(int c = 1);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(logic [7:0] d);
        reg_addr = HCR_OFFSET;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick();
        reg_wr = 1'b0;
        tick();
    endtask
    task automatic rd_chk(logic [7:0] e);
        reg_addr = HCR_OFFSET;
        reg_rd = 1'b1;
        tick();
        reg_rd = 1'b0;
        chk("reg_rdata", e, reg_rdata);
        tick();
    endtask
    task automatic setmode(logic [1:0] m);
        mode_wdata = m;
        mode_wr = 1'b1;
        tick();
        mode_wr = 1'b0;
        tick();
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        eeprom_led_default = $random(seed);
        memory_space_mapped = $random(seed);
        io_space_mapped = $random(seed);
        sh = {eeprom_led_default, 6'h00};
        tick(4);
        rst_n = 1'b1;
        tick(3);
        chk("led_mode_select", sh[7:6], led_mode_select);
        rd_chk(exp_rd());
        wr(8'hFF);
        rd_chk(exp_rd());
        setmode(HCR_EEM_CFG_WR);
        for (n = 0; n < 12; n++) begin
            wv = (n == 0) ? 8'hFF : 8'($random(seed));
            wr(wv);
            sh = wv & 8'hF1;
            memory_space_mapped = $random(seed);
            io_space_mapped = $random(seed);
            rd_chk(exp_rd());
            chk("cap_pointer", sh[0] ? HCR_CAP_PTR : 8'h00, cap_pointer);
            chk("cap_id", sh[0] ? HCR_CAP_ID : 8'h00, cap_id);
            chk("cap_flags", {6'h00, {2{sh[0]}}}, {6'h00, cap_list_status, cap_word_valid});
            chk("cap_next_ptr", 8'h00, cap_next_ptr);
            chk("power_mgmt_enable", 8'(sh[0]), 8'(power_mgmt_enable));
            pm_cfg_addr = 8'h51 + 8'(n % 8);
            tick();
            chk("pm_cfg_hit", sh[0] && pm_cfg_addr >= 8'h52 && pm_cfg_addr <= 8'h57, pm_cfg_hit);
        end
        wr(8'h21);
        pci_cmd_enable_write = 1'b1;
        tick();
        pci_cmd_enable_write = 1'b0;
        tick();
        sh = 8'h01;
        rd_chk(exp_rd());
        // Clear and software write of 1 in one cycle
        reg_addr = HCR_OFFSET;
        reg_wdata = 8'h21;
        reg_wr = 1'b1;
        pci_cmd_enable_write = 1'b1;
        tick();
        reg_wr = 1'b0;
        pci_cmd_enable_write = 1'b0;
        tick();
        rd_chk(exp_rd());
        for (n = 0; n < 4; n++) begin
            wr({sh[7:5], n[0], 3'h0, sh[0]});
            sh[4] = n[0];
            wake_pin_pulse_select = n[1];
            tick(WC + 4);
            chk("wake_idle", 8'(n[0]), wake_output_pin);
            wake_event = 1'b1;
            k = 0;
            repeat (WC + 8) begin
                tick();
                if (wake_output_pin === ~n[0])
                    k++;
            end
            chk("wake_active", n[1] ? WC : WC + 8, 8'(k));
            wake_event = 1'b0;
        end
        eeprom_led_default = ~sh[7:6];
        setmode(HCR_EEM_AUTOLOAD);
        k = 0;
        while (autoload_done !== 1'b1 && k < LC + 10) begin
            tick();
            k++;
        end
        chk("autoload_span", 8'h01, 8'(k >= LC - 2 && k <= LC + 4));
        tick();
        chk("autoload_done", 8'h00, 8'(autoload_done));
        sh = {eeprom_led_default, 6'h00};
        rd_chk(exp_rd());
        chk("cap_pointer", 8'h00, cap_pointer);
        test_done();
    end

    initial begin
        #(25 * 5000);
        error_cnt++;
        test_done();
    end
endmodule // test_host_config_register_one
